// File: bench/smbcc_slave_model.sv
`timescale 1ns/1ps
// Slave that acks each byte whose top seven bits match its address.
module smbcc_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe = 1'h0,
  output logic      in_frame = 1'h0,
  output logic [7:0] last_byte
);
  int         cnt = 0;
  logic [7:0] sh;
  // A START opens a frame and a STOP closes it.
  always @(negedge sda) if (scl) begin
    in_frame = 1'h1;
    cnt = 0;
  end
  always @(posedge sda) if (scl) in_frame = 1'h0;
  // Bits are taken MSB first on the rising clock.
  always @(posedge scl) if (in_frame && cnt < 8) begin
    sh = {sh[6:0], sda};
    cnt++;
  end
  // The ack is pulled low for the ninth clock only.
  always @(negedge scl) if (in_frame && cnt == 8) begin
    sda_oe <= (sh[7:1] == ADDR);
    last_byte <= sh;
    cnt = 9;
  end else if (cnt == 9) begin
    sda_oe <= 1'h0;
    cnt = 0;
  end
endmodule

// File: bench/test_smbus_config_and_control.sv
`timescale 1ns/1ps
`define CHK(a,b) begin samples_checked++; if ((a)!==(b)) begin fail_count++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_smbus_config_and_control;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp, tdiv = 2'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, s_oe, reload, cnt_en, si, in_frame;
  logic [3:0]  ovf = 4'h0;
  logic [7:0]  lbyte, v;
  logic [7:0]  sent_q[$];
  wire         scl_w = !scl_oe;
  wire         sda_w = !(sda_oe || s_oe);
  int          fail_count = 0, samples_checked = 0;
  always #12.5 aclk = ~aclk;
  // Each overflow source pulses once in a four-cycle round.
  always @(posedge aclk) begin
    tdiv <= tdiv + 2'h1;
    ovf <= 4'h1 << tdiv;
  end
  smbcc_core i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
    .tmr0_ovf(ovf[0]), .tmr1_ovf(ovf[1]), .tmr2_hi_ovf(ovf[2]), .tmr2_lo_ovf(ovf[3]), .tmr3_reload(reload),
    .tmr3_count_en(cnt_en), .si_flag(si)
  );
  smbcc_slave_model i_slv (.scl(scl_w), .sda(sda_w), .sda_oe(s_oe), .in_frame(in_frame), .last_byte(lbyte));
  // Register write; address and data are held until both are taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    if (a == 12'h308) sent_q.push_back(d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    bready <= 1'h1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
    `CHK(bresp, 2'h0)
  endtask
  // Register read; data and response code are both compared.
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
    `CHK(rdata, {24'h0, e})
    `CHK(rresp, r)
  endtask
  // Bounded wait for the interrupt flag to reach a level.
  task automatic wait_si(input logic lvl);
    for (int n = 0; n < 4000 && si !== lvl; n++) @(posedge aclk);
    `CHK(si, lvl)
  endtask
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    summarize();
  end
  // Main sequence: reset values, configuration, one master write.
  initial begin
    void'($urandom(32'hD6B8));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(12'h304, 8'h00);
    rd(12'h300, 8'h00);
    rd(12'h3FC, 8'h00, 2'h2);
    for (int i = 0; i < 4; i++) begin
      v = (8'($urandom) & 8'h5C) | 8'(i);
      wr(12'h304, v);
      rd(12'h304, v);
    end
    wr(12'h304, 8'h88);
    `CHK({reload, cnt_en}, 2'h2)
    wr(12'h304, 8'h00);
    `CHK({reload, cnt_en}, 2'h0)
    wr(12'h304, 8'hC0);
    wr(12'h300, 8'h20);
    wait_si(1'h1);
    `CHK(scl_oe, 1'h1)
    rd(12'h300, 8'hE1);
    rd(12'h304, 8'hE0);
    wr(12'h308, 8'h54);
    wr(12'h300, 8'h00);
    wait_si(1'h1);
    rd(12'h300, 8'hC3);
    v = sent_q.pop_front();
    `CHK(lbyte, v)
    wr(12'h300, 8'h10);
    for (int n = 0; n < 4000 && in_frame; n++) @(posedge aclk);
    repeat (8) @(posedge aclk);
    rd(12'h300, 8'h00);
    rd(12'h304, 8'hC0);
    summarize();
  end
endmodule

// File: hw/smbcc_core.sv
`timescale 1ns/1ps
`include "smbcc_map.svh"
// Overview of operation
// R01 - Flag rises per byte or address: after ack when sending, before ack when receiving.
// R02 - Flag also rises on own START as master and on STOP as slave.
// R03 - Enable bit set: take part and watch both lines; clear: interface inactive.
// R04 - Inhibit: NACK every address, no slave flags, effective from next START.
// R05 - Two-bit source field picks timer 0, 1, 2-high or 2-low overflow strobe.
// R06 - Overflow strobe used only as master or with bus-free timeout enabled.
// R07 - Master holds SCL low and high at least one overflow period each.
// R08 - SDA hold 3 clocks normally; extended setup 11 and hold 12 clocks.
// R09 - Software keeps the extension bit clear above 100 kHz.
// R10 - SCL-low timeout on: timer 3 reloads while SCL high, counts while low.
// R11 - Software sets timer 3 to 25 ms and restarts by toggling enable.
// R12 - Both lines high over 10 periods counts as STOP: flag and stop bit.
// R13 - Busy bit set during transfers, cleared on STOP or bus-free timeout.
// R14 - Read-only master and transmit bits join start and stop as status vector.
// R15 - Start and stop flags show conditions seen since the previous flag.
// R16 - Writing start enters master mode when bus free; hardware keeps start set.
// R17 - Stop as master ends after next ack; start plus stop gives STOP then START.
// R18 - Receiver writes outgoing ack; transmitter reads last ack; request flag per byte.
// R19 - Unwritten ack means NACK; SDA follows ack at once, SCL low until flag clear.
// R20 - After NACKing its address the slave ignores events until next START.
// R21 - Lost arbitration sets a flag, cleared whenever the interrupt flag clears.
// R22 - While the interrupt flag is set the bus stalls with SCL low.
// R23 - Only hardware sets the interrupt flag; software clears it to release.
// R24 - Writing one to ack sends ACK, zero sends NACK.
// R25 - Master mode lasts from own START until lost arbitration or own STOP.
// R26 - Transmit bit set if data written before a frame, cleared otherwise.
// R27 - Lines are driven only low, open drain, and sensed at their real level.
module smbcc_core #(
  parameter int ADDR_W       = 12,
  parameter int FREE_PERIODS = `SMBCC_FREE_PERIODS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic              tmr0_ovf,
  input  wire logic              tmr1_ovf,
  input  wire logic              tmr2_hi_ovf,
  input  wire logic              tmr2_lo_ovf,
  output logic                   tmr3_reload,
  output logic                   tmr3_count_en,
  output logic                   si_flag
);
  import smbcc_pkg::*;

  // Refuse sizes the decoder or the free counter cannot serve.
  if (ADDR_W < 12 || FREE_PERIODS < 1 || FREE_PERIODS > 14) begin : g_bad_param
    $error("smbcc_core: unsupported parameter value");
  end

  // Map a word address onto one of the three registers.
  function automatic smbcc_rsel_t reg_sel(input logic [ADDR_W-1:0] a);
    if (a[11:2] == `SMBCC_IDX_CTL) begin
      return RS_CTL;
    end else if (a[11:2] == `SMBCC_IDX_CFG) begin
      return RS_CFG;
    end else if (a[11:2] == `SMBCC_IDX_DAT) begin
      return RS_DAT;
    end else begin
      return RS_NONE;
    end
  endfunction

  logic [7:0] cfg_q, data_q;
  logic       bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] scl_s_q, sda_s_q;
  logic       scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  logic [4:0] lo_cnt_q;
  logic [3:0] free_cnt_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] per_cnt_q;
  smbcc_mst_t mst_q;
  logic       mst_scl_q, stall_q, sda_low_q, rise_seen_q;
  logic       si_q, sta_q, sto_q, ack_request_flag_q, arb_q, ack_q, master_q, transmit_indicator_q, busy_q;
  logic       addr_phase_q, slave_act_q, ignore_q, inh_act_q, data_wr_q;

  // Bus write and read strobes; one write and one read are held at a time.
  logic        wr_fire, rd_fire, wr_lane, ena, eng_rst;
  smbcc_rsel_t wsel, rsel;
  assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign rd_fire       = s_axi_arvalid & ~rvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign wsel          = reg_sel(s_axi_awaddr);
  assign rsel          = reg_sel(s_axi_araddr);
  assign wr_lane       = wr_fire & s_axi_wstrb[0];
  assign ena           = cfg_q[`SMBCC_CFG_ENA];
  assign eng_rst       = ~aresetn | ~ena; // R03
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Write response: unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SMBCC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wsel == RS_NONE) ? `SMBCC_RESP_SLVERR : `SMBCC_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data: the status vector and busy bit show live hardware state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `SMBCC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rsel == RS_NONE) ? `SMBCC_RESP_SLVERR : `SMBCC_RESP_OKAY;
      if (rsel == RS_CTL) begin
        rdata_q <= {24'h00_0000, master_q, transmit_indicator_q, sta_q, sto_q, ack_request_flag_q, arb_q, ack_q, si_q}; // R14 R15
      end else if (rsel == RS_CFG) begin
        rdata_q <= {24'h00_0000, cfg_q[7:6], busy_q, cfg_q[4:0]}; // R13
      end else if (rsel == RS_DAT) begin
        rdata_q <= {24'h00_0000, data_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Configuration register; the busy position is read-only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `SMBCC_CFG_RST;
    end else if (wr_lane && wsel == RS_CFG) begin
      cfg_q <= s_axi_wdata[7:0] & `SMBCC_CFG_WMASK;
    end
  end

  // Three-stage line samplers; a level counts once stages two and three agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i}; // R27
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // Line events seen on the filtered levels.
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_f_q & ~scl_p_q;
  assign scl_fall  = ~scl_f_q & scl_p_q;
  assign start_det = ena & scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign stop_det  = ena & scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // Bit-timing strobe selection, gated off when neither user needs it.
  logic ovf_raw, ovf;
  always_comb begin
    case (smbcc_csel_t'(cfg_q[1:0])) // R05
      CS_T0:   ovf_raw = tmr0_ovf;
      CS_T1:   ovf_raw = tmr1_ovf;
      CS_T2H:  ovf_raw = tmr2_hi_ovf;
      default: ovf_raw = tmr2_lo_ovf;
    endcase
  end
  assign ovf = ovf_raw & (master_q | cfg_q[`SMBCC_CFG_FTE] | (mst_q != ST_IDLE)); // R06

  // Setup and hold guards counted from the sensed SCL fall.
  logic [4:0] hold_c, setup_c;
  logic       hold_ok, release_ok;
  assign hold_c     = cfg_q[`SMBCC_CFG_EXT] ? `SMBCC_HOLD_EXT : `SMBCC_HOLD_STD; // R08
  assign setup_c    = cfg_q[`SMBCC_CFG_EXT] ? `SMBCC_SETUP_EXT : `SMBCC_SETUP_STD;
  assign hold_ok    = ~scl_f_q & (lo_cnt_q >= hold_c);
  assign release_ok = ~scl_f_q & (lo_cnt_q >= hold_c + setup_c);

  // Clocks since SCL fell, and overflow periods with both lines high.
  always_ff @(posedge aclk) begin
    if (eng_rst || scl_f_q) begin
      lo_cnt_q <= 5'h00;
    end else if (lo_cnt_q != 5'h1F) begin
      lo_cnt_q <= lo_cnt_q + 5'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (eng_rst || !(cfg_q[`SMBCC_CFG_FTE] && scl_f_q && sda_f_q)) begin
      free_cnt_q <= 4'h0;
    end else if (ovf && free_cnt_q != 4'hF) begin
      free_cnt_q <= free_cnt_q + 4'h1;
    end
  end

  // Timer 3 watches for SCL held low too long.
  assign tmr3_reload   = cfg_q[`SMBCC_CFG_TOE] & scl_f_q;  // R10
  assign tmr3_count_en = cfg_q[`SMBCC_CFG_TOE] & ~scl_f_q; // R10

  // Participation in the current frame.
  logic tx_drive, rx_part, boundary;
  assign tx_drive = transmit_indicator_q & (master_q | slave_act_q);
  assign rx_part  = ~transmit_indicator_q & (master_q | ((slave_act_q | addr_phase_q) & ~inh_act_q & ~ignore_q)); // R04 R20
  assign boundary = (bit_cnt_q == 4'h0);

  // Hardware events that set the interrupt flag.
  logic ev_mstart, ev_mstop, ev_arb, ev_rxbyte, ev_txack, ev_sstop, ev_free, si_set, si_clr;
  // SCL falls only once our own START is sensed, so that detecting it cannot undo the master state.
  assign ev_mstart = (mst_q == ST_START) & ovf & scl_f_q & ~sda_f_q; // R07
  assign ev_mstop  = (mst_q == ST_STOP_HIGH) & ovf & scl_f_q & (per_cnt_q != 2'h0);
  assign ev_arb    = (scl_rise & (bit_cnt_q < 4'h8) & tx_drive & ~sda_low_q & ~sda_f_q)
                   | (((mst_q == ST_STOP_HIGH) | (mst_q == ST_RS_HIGH)) & (per_cnt_q != 2'h0) & ~scl_f_q);
  assign ev_rxbyte = scl_fall & rise_seen_q & (bit_cnt_q == 4'h7) & rx_part;
  assign ev_txack  = scl_fall & rise_seen_q & (bit_cnt_q == 4'h8) & tx_drive;
  assign ev_sstop  = stop_det & slave_act_q & ~master_q;
  assign ev_free   = ovf & busy_q & (free_cnt_q == 4'(FREE_PERIODS)) & scl_f_q & sda_f_q;
  assign si_set    = ev_mstart | ev_arb | ev_rxbyte | ev_txack | ev_sstop | ev_free; // R01 R02 R12
  assign si_clr    = wr_lane & (wsel == RS_CTL) & ~s_axi_wdata[`SMBCC_CTL_SI];

  // Data the frame wants on SDA during SCL low.
  logic sda_want;
  always_comb begin
    if (mst_q == ST_LOW && boundary && !si_q && sto_q) begin
      sda_want = 1'b1;
    end else if (bit_cnt_q < 4'h8 && (transmit_indicator_q | data_wr_q) && (master_q | slave_act_q)) begin
      sda_want = ~data_q[7];
    end else if (bit_cnt_q == 4'h8 && rx_part) begin
      sda_want = ack_q; // R19 R24
    end else begin
      sda_want = 1'b0;
    end
  end

  // Master sequencer: START, clock phases, STOP and repeated START.
  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      mst_q     <= ST_IDLE;
      per_cnt_q <= 2'h0;
      mst_scl_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      if (ovf && (mst_q == ST_LOW || scl_f_q) && per_cnt_q != 2'h3) begin
        per_cnt_q <= per_cnt_q + 2'h1;
      end
      case (mst_q)
        ST_IDLE: begin
          mst_scl_q <= 1'b0;
          if (hold_ok) begin
            sda_low_q <= sda_want;
          end
          if (sta_q && !busy_q && !si_q && scl_f_q && sda_f_q) begin // R16
            mst_q     <= ST_START;
            per_cnt_q <= 2'h0;
            sda_low_q <= 1'b1;
          end
        end
        ST_START: begin
          if (ev_mstart) begin // R07
            mst_q     <= ST_LOW;
            per_cnt_q <= 2'h0;
            mst_scl_q <= 1'b1;
          end
        end
        ST_LOW: begin
          if (hold_ok) begin
            sda_low_q <= sda_want; // R08
          end
          if (!master_q) begin
            mst_q     <= ST_IDLE;
            mst_scl_q <= 1'b0;
          end else if (per_cnt_q >= `SMBCC_LOW_OVF && release_ok && !si_q) begin // R07 R22
            per_cnt_q <= 2'h0;
            mst_scl_q <= 1'b0;
            if (boundary && sto_q) begin // R17
              mst_q <= ST_STOP_HIGH;
            end else if (boundary && sta_q) begin
              mst_q <= ST_RS_HIGH;
            end else begin
              mst_q <= ST_HIGH;
            end
          end
        end
        ST_HIGH: begin
          if (ev_arb) begin // R25
            mst_q <= ST_IDLE;
          end else if (per_cnt_q >= `SMBCC_HIGH_OVF && scl_f_q) begin // R07
            mst_q     <= ST_LOW;
            per_cnt_q <= 2'h0;
            mst_scl_q <= 1'b1;
          end
        end
        ST_STOP_HIGH: begin
          if (ev_arb) begin
            mst_q     <= ST_IDLE;
            sda_low_q <= 1'b0;
          end else if (ev_mstop) begin
            mst_q     <= ST_IDLE;
            sda_low_q <= 1'b0;
          end
        end
        ST_RS_HIGH: begin
          if (ev_arb) begin
            mst_q <= ST_IDLE;
          end else if (ovf && scl_f_q && per_cnt_q != 2'h0) begin
            mst_q     <= ST_START;
            per_cnt_q <= 2'h0;
            sda_low_q <= 1'b1;
          end
        end
        default: mst_q <= ST_IDLE;
      endcase
    end
  end

  // A slave stretches SCL low for as long as its interrupt flag stands.
  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= si_q & ~si_clr & ~master_q & ~scl_f_q; // R22
    end
  end
  assign scl_oe  = mst_scl_q | stall_q; // R27
  assign sda_oe  = sda_low_q;           // R27
  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign si_flag = si_q;

  // Bit counter, shift register and slave address handling.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= `SMBCC_DAT_RST;
    end else if (wr_lane && wsel == RS_DAT) begin
      data_q <= s_axi_wdata[7:0];
    end else if (ena && scl_rise && bit_cnt_q < 4'h8) begin
      data_q <= {data_q[6:0], sda_f_q};
    end
  end
  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      bit_cnt_q    <= 4'h0;
      rise_seen_q  <= 1'b0;
      addr_phase_q <= 1'b0;
      slave_act_q  <= 1'b0;
      ignore_q     <= 1'b0;
      inh_act_q    <= 1'b0;
      data_wr_q    <= 1'b0;
    end else begin
      if (wr_lane && wsel == RS_DAT) begin
        data_wr_q <= 1'b1;
      end else if (scl_rise && boundary) begin
        data_wr_q <= 1'b0;
      end
      if (start_det) begin
        bit_cnt_q    <= 4'h0;
        rise_seen_q  <= 1'b0;
        addr_phase_q <= 1'b1;
        slave_act_q  <= 1'b0;
        ignore_q     <= 1'b0; // R20
        inh_act_q    <= cfg_q[`SMBCC_CFG_INH]; // R04
      end else if (stop_det || ev_free) begin
        slave_act_q  <= 1'b0;
        addr_phase_q <= 1'b0;
      end else if (scl_rise) begin
        rise_seen_q <= 1'b1;
      end else if (scl_fall && rise_seen_q) begin
        rise_seen_q <= 1'b0;
        bit_cnt_q   <= (bit_cnt_q == 4'h8) ? 4'h0 : bit_cnt_q + 4'h1;
        if (bit_cnt_q == 4'h8 && addr_phase_q) begin
          addr_phase_q <= 1'b0;
          if (!master_q && ack_q && !inh_act_q && !ignore_q) begin
            slave_act_q <= 1'b1;
          end else if (!master_q) begin
            ignore_q <= 1'b1; // R20
          end
        end
      end
    end
  end

  // Control and status flags; a hardware set wins over a software clear.
  logic ctl_wr;
  assign ctl_wr = wr_lane & (wsel == RS_CTL);
  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      si_q     <= 1'b0;
      ack_request_flag_q  <= 1'b0;
      arb_q    <= 1'b0;
      master_q <= 1'b0;
      transmit_indicator_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      si_q <= si_set | (si_q & ~si_clr); // R22 R23
      arb_q <= ev_arb | (arb_q & ~si_clr); // R21
      if (ev_rxbyte) begin
        ack_request_flag_q <= 1'b1; // R18
      end else if (scl_fall && rise_seen_q && bit_cnt_q == 4'h8) begin
        ack_request_flag_q <= 1'b0;
      end
      if (ev_mstart) begin
        master_q <= 1'b1; // R25
      end else if (ev_mstop || ev_arb) begin
        master_q <= 1'b0; // R25
      end
      if (ev_mstart || (wr_lane && wsel == RS_DAT)) begin
        transmit_indicator_q <= 1'b1; // R26
      end else if (start_det || ev_arb || (scl_rise && boundary && !data_wr_q)) begin
        transmit_indicator_q <= 1'b0; // R26
      end
      if (start_det) begin
        busy_q <= 1'b1; // R13
      end else if (stop_det || ev_free) begin
        busy_q <= 1'b0; // R13
      end
    end
  end

  // Software-written bits that hardware also sets or clears.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sta_q <= 1'b0;
      sto_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      if (start_det) begin
        sta_q <= 1'b1; // R15
      end else if (ctl_wr) begin
        sta_q <= s_axi_wdata[`SMBCC_CTL_STA]; // R16
      end
      if (ev_sstop || ev_free) begin
        sto_q <= 1'b1; // R12 R15
      end else if (ev_mstop) begin
        sto_q <= 1'b0; // R17
      end else if (ctl_wr) begin
        sto_q <= s_axi_wdata[`SMBCC_CTL_STO];
      end
      if (ctl_wr) begin
        ack_q <= s_axi_wdata[`SMBCC_CTL_ACK]; // R18 R24
      end else if (ev_rxbyte) begin
        ack_q <= 1'b0; // R19
      end else if (scl_rise && bit_cnt_q == 4'h8 && tx_drive) begin
        ack_q <= ~sda_f_q; // R18
      end
    end
  end

  AST_OFF_RELEASES: assert property (@(posedge aclk) disable iff (!aresetn) // R03
    !ena |=> !scl_oe && !sda_oe) else $error("lines driven while disabled");
  AST_STALL_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn) // R22
    si_q && mst_q == ST_LOW && ena |=> mst_q == ST_LOW || !ena) else $error("master left low phase with flag set");
  AST_MSTART_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    ev_mstart && ena |=> si_q && master_q && transmit_indicator_q) else $error("start not flagged");
  AST_RX_BEFORE_ACK: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    ev_rxbyte && ena |=> si_q && ack_request_flag_q && bit_cnt_q == 4'h8) else $error("receive flag not before ack");
  AST_ARB_WITH_SI: assert property (@(posedge aclk) disable iff (!aresetn) // R21
    $fell(si_q) |-> !arb_q) else $error("arbitration flag outlived interrupt flag");
  AST_FREE_AS_STOP: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    ev_free && ena |=> si_q && sto_q && !busy_q) else $error("free timeout not handled as stop");
  AST_BUSY_STOP: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    stop_det |=> !busy_q) else $error("busy kept after stop");
  AST_HOLD_MIN: assert property (@(posedge aclk) disable iff (!aresetn) // R08
    ena && $past(ena) && mst_q == ST_LOW && $past(mst_q) == ST_LOW && $changed(sda_low_q)
    |-> $past(lo_cnt_q) >= $past(hold_c)) else $error("data changed inside hold time");
  AST_MSTOP_LEAVES: assert property (@(posedge aclk) disable iff (!aresetn) // R25
    ev_mstop && ena |=> !master_q && !sto_q && !sda_oe) else $error("master mode kept after stop");
  AST_T3_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    cfg_q[`SMBCC_CFG_TOE] && $fell(scl_f_q) |-> tmr3_count_en && !tmr3_reload) else $error("timer 3 not counting");
endmodule

// File: include/smbcc_map.svh
`ifndef SMBCC_MAP_SVH
`define SMBCC_MAP_SVH
// Register indexes; the byte address is four times the index.
`define SMBCC_IDX_CTL      10'h0C0
`define SMBCC_IDX_CFG      10'h0C1
`define SMBCC_IDX_DAT      10'h0C2
// Configuration register fields.
`define SMBCC_CFG_ENA      7
`define SMBCC_CFG_INH      6
`define SMBCC_CFG_BUSY     5
`define SMBCC_CFG_EXT      4
`define SMBCC_CFG_TOE      3
`define SMBCC_CFG_FTE      2
`define SMBCC_CFG_CS_HI    1
`define SMBCC_CFG_CS_LO    0
`define SMBCC_CFG_WMASK    8'hDF
// Control and status register fields.
`define SMBCC_CTL_MASTER   7
`define SMBCC_CTL_TX       6
`define SMBCC_CTL_STA      5
`define SMBCC_CTL_STO      4
`define SMBCC_CTL_ACK_REQUEST_FLAG    3
`define SMBCC_CTL_ARB      2
`define SMBCC_CTL_ACK      1
`define SMBCC_CTL_SI       0
// Reset values.
`define SMBCC_CFG_RST      8'h00
`define SMBCC_CTL_RST      8'h00
`define SMBCC_DAT_RST      8'h00
// Timing counts in system clocks and in overflow periods.
`define SMBCC_HOLD_STD     5'h03
`define SMBCC_SETUP_STD    5'h01
`define SMBCC_HOLD_EXT     5'h0C
`define SMBCC_SETUP_EXT    5'h0B
`define SMBCC_LOW_OVF      2'h1
`define SMBCC_HIGH_OVF     2'h2
`define SMBCC_FREE_PERIODS 10
// Bus answers.
`define SMBCC_RESP_OKAY    2'h0
`define SMBCC_RESP_SLVERR  2'h2
`endif

// File: include/smbcc_pkg.sv
package smbcc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_START     = 3'b001,
    ST_LOW       = 3'b010,
    ST_HIGH      = 3'b011,
    ST_STOP_HIGH = 3'b100,
    ST_RS_HIGH   = 3'b101
  } smbcc_mst_t;
  typedef enum logic [1:0] {
    CS_T0  = 2'b00,
    CS_T1  = 2'b01,
    CS_T2H = 2'b10,
    CS_T2L = 2'b11
  } smbcc_csel_t;
  typedef enum logic [1:0] {
    RS_NONE = 2'b00,
    RS_CTL  = 2'b01,
    RS_CFG  = 2'b10,
    RS_DAT  = 2'b11
  } smbcc_rsel_t;
endpackage
